// >>> rtl/rtc_domain_regulator_power_control.sv
// Always-on regulator shutdown and wake pin control with an AHB-Lite register slave
// Function
// R1: Either shutdown bit turns off all three regulators together.
// R2: After shutdown only wake pin, RTC alarm or core supply cycle re-enable.
// R3: Analog regulator is off only through the shutdown bits.
// R4: Core regulator off when its enable pin is high, or by shutdown bits.
// R5: Usb regulator is disabled from reset onward.
// R6: Usb regulator output pin is high-impedance while that regulator is off.
// R7: Register bits 15..5 read zero and ignore writes.
// R8: Wake drive bit resets to 1; 0 drives pin low, 1 leaves it open.
// R9: Wake direction bit: 0 input, 1 output.
// R10: As an input, a high wake pin level is a wake request.
// R11: Software keeps the wake pin an input when it should wake the device.
// R12: Bandgap shutdown bit also turns off power-on-reset and bandgap reference.
// R13: Software uses shutdown bits only with internal regulators powering the chip.
// R14: Regulator shutdown bit keeps the bandgap on for faster wake.
// R15: Shutdown is held in always-on state and cleared by a wake event.
`default_nettype none
module rtc_domain_regulator_power_control
    import rtc_pwr_pkg::*;
(
    // Clock and reset; reset stands for the RTC core supply power cycle
    input  wire logic                     hclk,
    input  wire logic                     hresetn,
    // AHB-Lite slave
    input  wire logic                     hsel,
    input  wire logic [31:0]              haddr,
    input  wire logic [1:0]               htrans,
    input  wire logic                     hwrite,
    input  wire logic [2:0]               hsize,
    input  wire logic [31:0]              hwdata,
    input  wire logic                     hready,
    output logic      [31:0]              hrdata,
    output logic                          hreadyout,
    output logic                          hresp,
    // Wake sources and core regulator enable pin
    input  wire logic                     wake_pin_in,
    input  wire logic                     rtc_alarm,
    input  wire logic                     rtc_alarm_enable,
    input  wire logic                     core_regulator_enable_pin,
    // Wake request pin drive
    output logic                          wake_pin_out,
    output logic                          wake_pin_oe_n,
    // Usb regulator output pin drive
    output logic                          usb_regulator_output_pin_oe_n,
    // Analog enables and clock-out enable
    output rtc_pwr_pkg::power_enables_s   power_enables,
    output logic                          clock_out_enable
);
    import rtc_pwr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic       wake_meta_reg;
    logic       wake_sync_reg;
    logic       alarm_meta_reg;
    logic       alarm_sync_reg;
    logic       alarm_en_meta_reg;
    logic       alarm_en_sync_reg;
    logic       ldo_en_meta_reg;
    logic       ldo_en_sync_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wake_meta_reg   <= 1'b0;
            wake_sync_reg   <= 1'b0;
            alarm_meta_reg  <= 1'b0;
            alarm_sync_reg  <= 1'b0;
            alarm_en_meta_reg <= 1'b0;
            alarm_en_sync_reg <= 1'b0;
            ldo_en_meta_reg <= 1'b0;
            ldo_en_sync_reg <= 1'b0;
        end else begin
            wake_meta_reg   <= wake_pin_in;
            wake_sync_reg   <= wake_meta_reg;
            // Gate only after both pins are synchronised, so no logic sees a raw pin
            alarm_meta_reg  <= rtc_alarm;
            alarm_sync_reg  <= alarm_meta_reg;
            alarm_en_meta_reg <= rtc_alarm_enable;
            alarm_en_sync_reg <= alarm_en_meta_reg;
            ldo_en_meta_reg <= core_regulator_enable_pin;
            ldo_en_sync_reg <= ldo_en_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite address phase capture
    logic        wr_pend_reg;
    logic        rd_pend_reg;
    logic        addr_hit_reg;
    logic [15:0] pmgt_reg;
    logic [15:0] pmgt_next;

    wire         trans_valid = hsel & hready & htrans[1];
    wire         addr_hit    = (haddr[15:0] == PMGT_OFFSET) && (haddr[31:16] == 16'h0000);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg  <= 1'b0;
            rd_pend_reg  <= 1'b0;
            addr_hit_reg <= 1'b0;
        end else begin
            wr_pend_reg  <= trans_valid & hwrite;
            rd_pend_reg  <= trans_valid & ~hwrite;
            addr_hit_reg <= addr_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power state, held in the always-on domain
    power_state_e state_reg;
    power_state_e state_next;

    wire wake_dir     = pmgt_reg[WAKE_DIR_BIT];
    // A high level on the pin counts only while the pin is an input
    wire wake_request = ~wake_dir & wake_sync_reg;                  // [R10] [R9]
    wire wake_event   = wake_request | (alarm_sync_reg & alarm_en_sync_reg); // [R2]
    wire reg_write    = wr_pend_reg & addr_hit_reg;
    wire [15:0] wdata_masked = hwdata[15:0] & PMGT_WRITE_MASK;      // [R7]
    wire req_bg_off   = reg_write & wdata_masked[BG_SHUTDOWN_BIT];
    wire req_reg_off  = reg_write & wdata_masked[REG_SHUTDOWN_BIT];

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            PWR_ON: begin
                if (req_bg_off) begin
                    state_next = PWR_ALL_OFF;                       // [R12] [R1]
                end else if (req_reg_off) begin
                    state_next = PWR_REG_OFF;                       // [R14] [R1]
                end
            end
            PWR_REG_OFF: begin
                // Wake wins over a fresh write; deeper request still honoured
                if (wake_event) begin
                    state_next = PWR_ON;                            // [R2] [R15]
                end else if (req_bg_off) begin
                    state_next = PWR_ALL_OFF;
                end
            end
            PWR_ALL_OFF: begin
                if (wake_event) begin
                    state_next = PWR_ON;                            // [R2] [R15]
                end
            end
            default: state_next = PWR_ON;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= PWR_ON;
        end else begin
            state_reg <= state_next;                                // [R15]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register file: shutdown bits mirror the held state so a wake clears them
    always_comb begin
        pmgt_next = pmgt_reg;
        if (reg_write) begin
            pmgt_next = wdata_masked;                               // [R7]
        end
        pmgt_next[BG_SHUTDOWN_BIT]  = (state_next == PWR_ALL_OFF);  // [R15]
        pmgt_next[REG_SHUTDOWN_BIT] = (state_next == PWR_REG_OFF);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pmgt_reg <= PMGT_RESET;                                 // [R8]
        end else begin
            pmgt_reg <= pmgt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus answers: zero wait states, always OKAY; unmapped reads return zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= HRESP_OKAY;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= HRESP_OKAY;
            if (trans_valid & ~hwrite & addr_hit) begin
                hrdata <= {16'h0000, pmgt_next};                    // [R7]
            end else begin
                hrdata <= 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    wire shutdown   = (state_next != PWR_ON);                       // [R1]
    wire bg_off     = (state_next == PWR_ALL_OFF);                  // [R12]
    // Direction and level come from the same next value, so the pin changes in one step
    wire drive_low  = pmgt_next[WAKE_DIR_BIT] & ~pmgt_next[WAKE_DRIVE_BIT]; // [R8] [R9]

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            power_enables                 <= '{default: 1'b0};
            wake_pin_out                  <= 1'b0;
            wake_pin_oe_n                 <= 1'b1;
            usb_regulator_output_pin_oe_n <= 1'b1;
            clock_out_enable              <= 1'b0;
        end else begin
            power_enables.analog_regulator_en <= ~shutdown;         // [R3]
            power_enables.core_regulator_en   <= ~shutdown & ~ldo_en_sync_reg; // [R4]
            power_enables.usb_regulator_en    <= 1'b0;              // [R5]
            power_enables.analog_por_en       <= ~shutdown;         // [R12]
            power_enables.bandgap_en          <= ~bg_off;           // [R12] [R14]
            wake_pin_out                      <= 1'b0;
            wake_pin_oe_n                     <= ~drive_low;        // [R8]
            usb_regulator_output_pin_oe_n     <= 1'b1;              // [R6]
            clock_out_enable                  <= pmgt_next[CLKOUT_EN_BIT];
        end
    end
endmodule // rtc_domain_regulator_power_control
`default_nettype wire

// >>> rtl/rtc_pwr_pkg.sv
// Package: register map, field layout and carrier types of the RTC power control block
`default_nettype none
package rtc_pwr_pkg;
    // Register byte address and word width
    localparam logic [15:0] PMGT_OFFSET        = 16'h1930;
    localparam int          PMGT_WIDTH         = 16;
    // Field positions
    localparam int          CLKOUT_EN_BIT      = 0;
    localparam int          REG_SHUTDOWN_BIT   = 1;
    localparam int          BG_SHUTDOWN_BIT    = 2;
    localparam int          WAKE_DIR_BIT       = 3;
    localparam int          WAKE_DRIVE_BIT     = 4;
    // Writable bits; bits 15..5 are reserved
    localparam logic [15:0] PMGT_WRITE_MASK    = 16'h001f;
    localparam logic [15:0] PMGT_RESET         = 16'h0010;
    // AHB encodings
    localparam logic [1:0]  HTRANS_NONSEQ      = 2'h2;
    localparam logic [1:0]  HTRANS_SEQ         = 2'h3;
    localparam logic        HRESP_OKAY         = 1'h0;

    // Analog enables that leave the block
    typedef struct packed {
        logic analog_regulator_en;
        logic core_regulator_en;
        logic usb_regulator_en;
        logic analog_por_en;
        logic bandgap_en;
    } power_enables_s;

    // Wake request pin, split into its two signals
    typedef struct packed {
        logic wake_out;
        logic wake_oe_n;
    } wake_pin_s;

    typedef enum logic [1:0] {
        PWR_ON       = 2'b00,
        PWR_REG_OFF  = 2'b01,
        PWR_ALL_OFF  = 2'b10
    } power_state_e;
endpackage : rtc_pwr_pkg
`default_nettype wire

// >>> verif/rtc_pwr_props.sv
// Checker: bus, shutdown, wake and pin relations of the RTC power control block
`default_nettype none
module rtc_pwr_props
    import rtc_pwr_pkg::*;
(
    input wire logic              hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp,
    input wire logic [31:0]       haddr, hwdata, hrdata,
    input wire logic [1:0]        htrans,
    input wire logic              wake_pin_in, rtc_alarm, rtc_alarm_enable,
    input wire logic              core_regulator_enable_pin, wake_pin_out, wake_pin_oe_n,
    input wire logic              usb_regulator_output_pin_oe_n,
    input wire rtc_pwr_pkg::power_enables_s power_enables
);
    logic        wr_ph;
    logic        rd_ph;
    logic [31:0] wd;
    wire  logic  take = hsel && hready && htrans[1] && haddr == {16'h0000, PMGT_OFFSET};
    wire  logic  wk   = wake_pin_in || (rtc_alarm && rtc_alarm_enable);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ph <= 1'b0;
            rd_ph <= 1'b0;
        end else begin
            wr_ph <= take && hwrite;
            rd_ph <= take && !hwrite;
        end
    end
    always_ff @(posedge hclk) wd <= hwdata;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // A wake still in the synchronisers would win over the write, so demand a quiet lead-in
    sequence quiet_wr;
        (!wk)[*3] ##1 (wr_ph && !wk);
    endsequence
    a_bg_all_off: assert property (quiet_wr ##0 hwdata[2] |=> power_enables == 5'h00)
        else $error("bandgap shutdown left an enable on");
    a_reg_keeps_bg: assert property (quiet_wr ##0 (hwdata[2:1] == 2'h1) |=>
        power_enables[4:1] == 4'h0 && $stable(power_enables.bandgap_en))
        else $error("regulator shutdown wrong");
    a_usb_off: assert property (!power_enables.usb_regulator_en && usb_regulator_output_pin_oe_n)
        else $error("usb regulator not off");
    a_open_drain: assert property (!wake_pin_out)
        else $error("wake pin driven high");
    a_wake_drive: assert property (wr_ph |=> wake_pin_oe_n == !(wd[3] && !wd[4]))
        else $error("wake pin enable wrong");
    a_core_strap: assert property (core_regulator_enable_pin [*4] |->
        !power_enables.core_regulator_en) else $error("core regulator on with strap high");
    a_core_follow: assert property ((!core_regulator_enable_pin)[*4] |->
        power_enables.core_regulator_en == power_enables.analog_regulator_en)
        else $error("core regulator not with analog");
    a_rise_on_wake: assert property ($rose(power_enables.analog_regulator_en) && $past(hresetn)
        && $past(hresetn, 2)
        |-> $past(wk, 2) || $past(wk, 3) || $past(wk, 4)) else $error("enable without wake");
    a_alarm_wakes: assert property ((rtc_alarm && rtc_alarm_enable)[*5] |->
        power_enables.analog_regulator_en && power_enables.bandgap_en && power_enables.analog_por_en)
        else $error("alarm did not wake");
    a_rsvd_zero: assert property (rd_ph |-> hrdata[31:5] == 27'h0)
        else $error("reserved bits not zero");
    a_bus_okay: assert property (hreadyout && hresp == HRESP_OKAY)
        else $error("bus not ready or not okay");
endmodule // rtc_pwr_props
bind rtc_domain_regulator_power_control rtc_pwr_props rtc_pwr_props_i (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .haddr(haddr), .hwdata(hwdata), .hrdata(hrdata), .htrans(htrans),
    .wake_pin_in(wake_pin_in), .rtc_alarm(rtc_alarm), .rtc_alarm_enable(rtc_alarm_enable),
    .core_regulator_enable_pin(core_regulator_enable_pin), .wake_pin_out(wake_pin_out),
    .wake_pin_oe_n(wake_pin_oe_n), .power_enables(power_enables),
    .usb_regulator_output_pin_oe_n(usb_regulator_output_pin_oe_n));
`default_nettype wire

// >>> verif/tb_rtc_domain_regulator_power_control.sv
// Testbench: register bus, shutdown, wake, strap and power cycle of the RTC power block
`default_nettype none
module tb_rtc_domain_regulator_power_control import rtc_pwr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, ext_en = 1, level = 0, rd_dp = 0;
    logic alarm_req = 0, rtc_alarm_enable = 0, strap = 0;
    logic [31:0] haddr = 0, hwdata = 0, rnd = 32'h0000e5ef;
    logic [1:0] htrans = 0;
    wire logic [31:0] hrdata;
    wire logic hreadyout, hresp, wake_pin_in, rtc_alarm, wake_pin_out, wake_pin_oe_n, usb_oe_n, ck_en;
    wire power_enables_s pe;
    int n_fail = 0, compares = 0;
    logic [31:0] exp_q[$];
    always #25 hclk = ~hclk;
    rtc_domain_regulator_power_control rtc_domain_regulator_power_control_i (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .wake_pin_in(wake_pin_in), .rtc_alarm(rtc_alarm),
        .rtc_alarm_enable(rtc_alarm_enable), .core_regulator_enable_pin(strap),
        .wake_pin_out(wake_pin_out), .wake_pin_oe_n(wake_pin_oe_n),
        .usb_regulator_output_pin_oe_n(usb_oe_n), .power_enables(pe), .clock_out_enable(ck_en));
    wake_source_model wake_source_model_i (.hclk(hclk), .wake_pin_oe_n(wake_pin_oe_n),
        .ext_en(ext_en), .level(level), .alarm_req(alarm_req), .wake_pin_in(wake_pin_in),
        .rtc_alarm(rtc_alarm));
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [31:0] e);
        @(posedge hclk);
        hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= HTRANS_NONSEQ;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d; rd_dp <= !w;
        if (!w) exp_q.push_back(e);
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd_dp <= 1'b0;
    endtask
    always @(posedge hclk) if (rd_dp && hreadyout) chk(hrdata, exp_q.pop_front());
    task pe_is(input logic [4:0] e);
        @(negedge hclk);
        chk({27'h0, pe}, {27'h0, e});
    endtask
    task wait_on;
        for (int i = 0; i < 8 && pe.analog_regulator_en !== 1'b1; i++) @(negedge hclk);
    endtask
    task close_out;
        $display("n_fail %0d compares %0d", n_fail, compares);
        if (n_fail == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #200000;
        n_fail++;
        close_out;
    end
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
        pe_is(5'h1b);
        chk({31'h0, usb_oe_n}, 32'h1);
        bus(0, 32'h1930, 0, 32'h10);
        for (int i = 0; i < 4; i++) begin
            rnd = xs(rnd);
            bus(1, 32'h1930, rnd & 32'hfffffff9, 0);
            bus(0, 32'h1930, 0, rnd & 32'h19);
            chk({31'h0, wake_pin_oe_n}, {31'h0, !(rnd[3] && !rnd[4])});
            chk({31'h0, wake_pin_out}, 32'h0);
            chk({31'h0, ck_en}, {31'h0, rnd[0]});
        end
        // Shutdown is only used with the internal regulators powering the chip
        bus(1, 32'h1930, 32'h12, 0);
        pe_is(5'h01);
        bus(1, 32'h1930, 32'h10, 0);
        bus(0, 32'h1930, 0, 32'h12);
        pe_is(5'h01);
        bus(1, 32'h1930, 32'h1c, 0);
        pe_is(5'h00);
        @(posedge hclk) ext_en <= 1'b0;
        repeat (6) @(posedge hclk);
        pe_is(5'h00);
        @(posedge hclk) ext_en <= 1'b1;
        bus(1, 32'h1930, 32'h14, 0);
        @(posedge hclk) level <= 1'b1;
        wait_on;
        pe_is(5'h1b);
        bus(0, 32'h1930, 0, 32'h10);
        @(posedge hclk) level <= 1'b0;
        bus(1, 32'h1930, 32'h12, 0);
        @(posedge hclk) alarm_req <= 1'b1;
        repeat (6) @(posedge hclk);
        pe_is(5'h01);
        @(posedge hclk) rtc_alarm_enable <= 1'b1;
        wait_on;
        pe_is(5'h1b);
        @(posedge hclk) alarm_req <= 1'b0;
        rtc_alarm_enable <= 1'b0;
        strap <= 1'b1;
        repeat (4) @(posedge hclk);
        pe_is(5'h13);
        bus(1, 32'h1934, 32'h14, 0);
        bus(0, 32'h1934, 0, 0);
        pe_is(5'h13);
        @(posedge hclk) strap <= 1'b0;
        bus(1, 32'h1930, 32'h14, 0);
        @(posedge hclk) hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (4) @(posedge hclk);
        pe_is(5'h1b);
        close_out;
    end
endmodule // tb_rtc_domain_regulator_power_control
`default_nettype wire

// >>> verif/wake_source_model.sv
// Partner: wake source circuitry beyond the wake pin, with pin pull-up and alarm source
`default_nettype none
module wake_source_model (
    input  wire logic hclk,
    input  wire logic wake_pin_oe_n,
    input  wire logic ext_en,
    input  wire logic level,
    input  wire logic alarm_req,
    output logic      wake_pin_in,
    output logic      rtc_alarm
);
    // Device pulls low; otherwise the external driver, else the pull-up wins
    assign wake_pin_in = !wake_pin_oe_n ? 1'b0 : (ext_en ? level : 1'b1);
    // Alarm arrives a cycle late, as a slow source would
    always_ff @(posedge hclk) rtc_alarm <= alarm_req;
endmodule // wake_source_model
`default_nettype wire
